// ---- design/risc_core_pkg.sv ----
package risc_core_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int PC_W = 9;
  localparam int PROG_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int PROG_WORDS = 512;
  localparam int GPR_BYTES = 25;

  // ****************************************
  // Timing
  // ****************************************
  localparam int INSTR_CYCLE_NS = 200;
  localparam int CLK_PERIOD_NS = 20;
  // Longest time, rounded down: clocks one instruction may take
  localparam int INSTR_CLKS_MAX = INSTR_CYCLE_NS / CLK_PERIOD_NS;

  // ****************************************
  // Data memory map
  // ****************************************
  localparam logic [4:0] ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] ADDR_PINS = 5'h01;
  localparam logic [4:0] ADDR_PCL = 5'h02;
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_FSR = 5'h04;
  localparam logic [4:0] ADDR_OUTA = 5'h05;
  localparam logic [4:0] ADDR_OUTB = 5'h06;
  localparam logic [4:0] ADDR_GPR_FIRST = 5'h07;

  // ****************************************
  // Status bits and reset values
  // ****************************************
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam logic [8:0] PC_RESET = 9'h000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [11:0] INSTR_NOP = 12'h000;

  // ****************************************
  // Instruction classes and file operations
  // ****************************************
  localparam logic [1:0] CLASS_FILE = 2'h0;
  localparam logic [1:0] CLASS_BIT = 2'h1;
  localparam logic [1:0] CLASS_JUMP = 2'h2;
  localparam logic [1:0] CLASS_LIT = 2'h3;

  typedef enum logic [3:0] {
    OP_MOVWF = 4'h0, OP_CLR = 4'h1, OP_SUB = 4'h2, OP_DEC = 4'h3,
    OP_IOR = 4'h4, OP_AND = 4'h5, OP_XOR = 4'h6, OP_ADD = 4'h7,
    OP_MOV = 4'h8, OP_COM = 4'h9, OP_INC = 4'hA, OP_DECSZ = 4'hB,
    OP_RRC = 4'hC, OP_RLC = 4'hD, OP_SWAP = 4'hE, OP_INCSZ = 4'hF
  } file_op_e;

  typedef enum logic [3:0] {
    ALU_PASS_B = 4'h0, ALU_PASS_A = 4'h1, ALU_ADD = 4'h2, ALU_SUB = 4'h3,
    ALU_AND = 4'h4, ALU_IOR = 4'h5, ALU_XOR = 4'h6, ALU_COM = 4'h7,
    ALU_INC = 4'h8, ALU_DEC = 4'h9, ALU_RRC = 4'hA, ALU_RLC = 4'hB,
    ALU_SWAP = 4'hC, ALU_CLR = 4'hD, ALU_BCLR = 4'hE, ALU_BSET = 4'hF
  } alu_op_e;

  typedef struct packed {
    alu_op_e op;
    logic useLit;
    logic toFile;
    logic toW;
    logic affCarry;
    logic affNibble;
    logic affZero;
    logic skipZero;
  } decode_s;

  typedef struct packed {
    logic carry;
    logic nibble;
    logic zero;
  } flags_s;

endpackage

// ---- design/risc_alu.sv ----
`timescale 1ns/100ps
`default_nettype none

module risc_alu #(
  parameter int WIDTH = 8
) (
  // Operands
  input wire logic [WIDTH-1:0] opA,
  input wire logic [WIDTH-1:0] opB,
  input wire risc_core_pkg::alu_op_e op,
  input wire logic [2:0] bitSel,
  input wire logic carryIn,
  // Result
  output logic [WIDTH-1:0] result,
  output risc_core_pkg::flags_s flags
);

  // Nibble flag is defined at bit 3 to 4, so only a byte fits
  if (WIDTH != 8)
  begin : gWidthCheck
    $error("risc_alu supports WIDTH = 8 only");
  end

  // Subtract as opB + ~opA + 1, so carry high means no borrow
  logic isSub;
  logic [WIDTH-1:0] addend;
  logic [WIDTH:0] sum;
  logic [4:0] lowSum;
  logic [WIDTH-1:0] bitMask;

  assign isSub = (op == risc_core_pkg::ALU_SUB);
  assign addend = isSub ? ~opA : opA;
  assign sum = {1'b0, opB} + {1'b0, addend} + {{WIDTH{1'b0}}, isSub};
  assign lowSum = {1'b0, opB[3:0]} + {1'b0, addend[3:0]} + {4'h0, isSub};
  assign bitMask = WIDTH'(1) << bitSel;

  always_comb
  begin
    flags.carry = carryIn;
    flags.nibble = lowSum[4];
    case (op)
      risc_core_pkg::ALU_PASS_B: result = opB;
      risc_core_pkg::ALU_PASS_A: result = opA;
      risc_core_pkg::ALU_ADD, risc_core_pkg::ALU_SUB:
      begin
        result = sum[WIDTH-1:0];
        flags.carry = sum[WIDTH];
      end
      risc_core_pkg::ALU_AND: result = opA & opB;
      risc_core_pkg::ALU_IOR: result = opA | opB;
      risc_core_pkg::ALU_XOR: result = opA ^ opB;
      risc_core_pkg::ALU_COM: result = ~opB;
      risc_core_pkg::ALU_INC: result = opB + WIDTH'(1);
      risc_core_pkg::ALU_DEC: result = opB - WIDTH'(1);
      risc_core_pkg::ALU_RRC:
      begin
        result = {carryIn, opB[WIDTH-1:1]};
        flags.carry = opB[0];
      end
      risc_core_pkg::ALU_RLC:
      begin
        result = {opB[WIDTH-2:0], carryIn};
        flags.carry = opB[WIDTH-1];
      end
      risc_core_pkg::ALU_SWAP: result = {opB[3:0], opB[7:4]};
      risc_core_pkg::ALU_CLR: result = '0;
      risc_core_pkg::ALU_BCLR: result = opB & ~bitMask;
      risc_core_pkg::ALU_BSET: result = opB | bitMask;
      default: result = opB;
    endcase
    flags.zero = (result == '0);
  end

endmodule

`default_nettype wire

// ---- design/risc_core_alu_datapath.sv ----
// Function
// - Each instruction is one 12-bit word fetched over its own program bus per cycle.
// - Program fetch and data access use separate buses in the same cycle.
// - Two-stage pipeline: next fetch overlaps execution of the current word.
// - Every non-branch instruction completes in one instruction cycle.
// - Branches take two cycles; the already fetched word is discarded.
// - Program counter addresses 512 internal 12-bit words, no external memory.
// - Register file provides 25 bytes of general-purpose RAM.
// - All special registers, low byte of the program counter included, sit in the data map.
// - Operands reachable directly and indirectly; any operation on any register.
// - 8-bit ALU adds, subtracts, shifts and does logic.
// - Arithmetic is two's complement.
// - Two-operand ops take working register and file register or literal.
// - Single-operand ops take a file register; the result goes to it or to the working register.
// - Working register is 8 bits, operand and destination, not in data map.
// - Carry, nibble and zero flags update per instruction; others stay unchanged.
// - In subtraction carry and nibble flag are inverted borrows: high when no borrow.
`timescale 1ns/100ps
`default_nettype none

module risc_core_alu_datapath #(
  parameter int PROG_WORDS = risc_core_pkg::PROG_WORDS,
  parameter int GPR_BYTES = risc_core_pkg::GPR_BYTES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Program bus
  output logic [risc_core_pkg::PC_W-1:0] progAddr,
  input wire logic [risc_core_pkg::PROG_W-1:0] progData,
  // Pins
  input wire logic [risc_core_pkg::DATA_W-1:0] pinsIn,
  output logic [risc_core_pkg::DATA_W-1:0] outA,
  output logic [risc_core_pkg::DATA_W-1:0] outB,
  // Observation
  output logic [risc_core_pkg::DATA_W-1:0] wOut,
  output logic [risc_core_pkg::DATA_W-1:0] statusOut
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (PROG_WORDS < 2 || PROG_WORDS > 2 ** risc_core_pkg::PC_W)
  begin : gProgCheck
    $error("PROG_WORDS out of range for the program counter");
  end
  if (GPR_BYTES < 1 || GPR_BYTES > 32 - int'(risc_core_pkg::ADDR_GPR_FIRST))
  begin : gGprCheck
    $error("GPR_BYTES does not fit the data map");
  end
  if (risc_core_pkg::INSTR_CLKS_MAX < 1)
  begin : gCycleCheck
    $error("Clock too slow for one instruction per cycle");
  end

  localparam logic [risc_core_pkg::PC_W-1:0] PC_LAST = (risc_core_pkg::PC_W)'(PROG_WORDS - 1);
  localparam logic [4:0] GPR_LAST = 5'(int'(risc_core_pkg::ADDR_GPR_FIRST) + GPR_BYTES - 1);

  // ****************************************
  // State
  // ****************************************
  logic [risc_core_pkg::PC_W-1:0] pcQ, pcD;
  logic [risc_core_pkg::PROG_W-1:0] instrQ;
  logic validQ, validD;
  logic [7:0] wQ, wD;
  logic [7:0] statusQ, statusD;
  logic [7:0] fsrQ;
  logic [7:0] outAQ;
  logic [7:0] outBQ;
  logic [7:0] gprQ [GPR_BYTES];

  // ****************************************
  // Field decode
  // ****************************************
  logic [1:0] iClass;
  logic [3:0] fileOp;
  logic destFile;
  logic [4:0] fileField;
  logic [4:0] effAddr;
  logic indirectNull;
  logic [2:0] bitSel;
  logic [7:0] literal;
  logic [4:0] gprIdx;
  logic isGpr;

  assign iClass = instrQ[11:10];
  assign fileOp = instrQ[9:6];
  assign destFile = instrQ[5];
  assign fileField = instrQ[4:0];
  assign bitSel = instrQ[7:5];
  assign literal = instrQ[7:0];
  // Address zero goes through the pointer register
  assign effAddr = (fileField == risc_core_pkg::ADDR_INDIRECT) ? fsrQ[4:0] : fileField;
  // Pointer aimed at itself reads zero and writes nothing, avoiding a loop
  assign indirectNull = (effAddr == risc_core_pkg::ADDR_INDIRECT);
  assign isGpr = (effAddr >= risc_core_pkg::ADDR_GPR_FIRST) && (effAddr <= GPR_LAST);
  assign gprIdx = effAddr - risc_core_pkg::ADDR_GPR_FIRST;

  // ****************************************
  // Operation decode
  // ****************************************
  risc_core_pkg::decode_s dec;

  always_comb
  begin
    dec = '0;
    dec.op = risc_core_pkg::ALU_PASS_B;
    case (iClass)
      risc_core_pkg::CLASS_FILE:
      begin
        dec.toFile = destFile;
        dec.toW = ~destFile;
        case (risc_core_pkg::file_op_e'(fileOp))
          risc_core_pkg::OP_MOVWF:
          begin
            dec.op = risc_core_pkg::ALU_PASS_A;
            dec.toW = 1'b0;
          end
          risc_core_pkg::OP_CLR:
          begin
            dec.op = risc_core_pkg::ALU_CLR;
            dec.affZero = 1'b1;
          end
          risc_core_pkg::OP_SUB:
          begin
            dec.op = risc_core_pkg::ALU_SUB;
            {dec.affCarry, dec.affNibble, dec.affZero} = 3'h7;
          end
          risc_core_pkg::OP_DEC:
          begin
            dec.op = risc_core_pkg::ALU_DEC;
            dec.affZero = 1'b1;
          end
          risc_core_pkg::OP_IOR:
          begin
            dec.op = risc_core_pkg::ALU_IOR;
            dec.affZero = 1'b1;
          end
          risc_core_pkg::OP_AND:
          begin
            dec.op = risc_core_pkg::ALU_AND;
            dec.affZero = 1'b1;
          end
          risc_core_pkg::OP_XOR:
          begin
            dec.op = risc_core_pkg::ALU_XOR;
            dec.affZero = 1'b1;
          end
          risc_core_pkg::OP_ADD:
          begin
            dec.op = risc_core_pkg::ALU_ADD;
            {dec.affCarry, dec.affNibble, dec.affZero} = 3'h7;
          end
          risc_core_pkg::OP_MOV: dec.affZero = 1'b1;
          risc_core_pkg::OP_COM:
          begin
            dec.op = risc_core_pkg::ALU_COM;
            dec.affZero = 1'b1;
          end
          risc_core_pkg::OP_INC:
          begin
            dec.op = risc_core_pkg::ALU_INC;
            dec.affZero = 1'b1;
          end
          risc_core_pkg::OP_DECSZ:
          begin
            dec.op = risc_core_pkg::ALU_DEC;
            dec.skipZero = 1'b1;
          end
          risc_core_pkg::OP_RRC:
          begin
            dec.op = risc_core_pkg::ALU_RRC;
            dec.affCarry = 1'b1;
          end
          risc_core_pkg::OP_RLC:
          begin
            dec.op = risc_core_pkg::ALU_RLC;
            dec.affCarry = 1'b1;
          end
          risc_core_pkg::OP_SWAP: dec.op = risc_core_pkg::ALU_SWAP;
          risc_core_pkg::OP_INCSZ:
          begin
            dec.op = risc_core_pkg::ALU_INC;
            dec.skipZero = 1'b1;
          end
          default: dec.op = risc_core_pkg::ALU_PASS_B;
        endcase
        // Store-W with destination bit low is the no-operation word
        if (fileOp == 4'h0)
        begin
          dec.toFile = destFile;
        end
      end
      risc_core_pkg::CLASS_BIT:
      begin
        dec.op = instrQ[8] ? risc_core_pkg::ALU_BSET : risc_core_pkg::ALU_BCLR;
        dec.toFile = ~instrQ[9];
      end
      risc_core_pkg::CLASS_LIT:
      begin
        dec.useLit = 1'b1;
        dec.toW = 1'b1;
        dec.affZero = (instrQ[9:8] != 2'h0);
        case (instrQ[9:8])
          2'h1: dec.op = risc_core_pkg::ALU_IOR;
          2'h2: dec.op = risc_core_pkg::ALU_AND;
          2'h3: dec.op = risc_core_pkg::ALU_XOR;
          default: dec.op = risc_core_pkg::ALU_PASS_B;
        endcase
      end
      default: dec.op = risc_core_pkg::ALU_PASS_B;
    endcase
  end

  // ****************************************
  // Data read path and ALU
  // ****************************************
  logic [7:0] fileRd;
  logic [7:0] aluB;
  logic [7:0] result;
  risc_core_pkg::flags_s aluFlags;

  assign fileRd = indirectNull ? 8'h00 :
    isGpr ? gprQ[gprIdx] :
    (effAddr == risc_core_pkg::ADDR_PINS) ? pinsIn :
    (effAddr == risc_core_pkg::ADDR_PCL) ? pcQ[7:0] :
    (effAddr == risc_core_pkg::ADDR_STATUS) ? statusQ :
    (effAddr == risc_core_pkg::ADDR_FSR) ? fsrQ :
    (effAddr == risc_core_pkg::ADDR_OUTA) ? outAQ :
    (effAddr == risc_core_pkg::ADDR_OUTB) ? outBQ : 8'h00;
  assign aluB = dec.useLit ? literal : fileRd;

  risc_alu #(
    .WIDTH(risc_core_pkg::DATA_W)
  ) uAlu (
    .opA(wQ),
    .opB(aluB),
    .op(dec.op),
    .bitSel(bitSel),
    .carryIn(statusQ[risc_core_pkg::ST_CARRY]),
    .result(result),
    .flags(aluFlags)
  );

  // ****************************************
  // Write enables and flow control
  // ****************************************
  logic fileWe;
  logic isGoto;
  logic bitTest;
  logic skip;
  logic pclWrite;
  logic flush;
  logic [risc_core_pkg::PC_W-1:0] pcInc;

  // Data write happens alongside the program fetch of the same cycle
  assign fileWe = validQ && dec.toFile && !indirectNull;
  assign isGoto = validQ && (iClass == risc_core_pkg::CLASS_JUMP) && !instrQ[9];
  assign bitTest = (iClass == risc_core_pkg::CLASS_BIT) && instrQ[9];
  assign skip = validQ && ((dec.skipZero && aluFlags.zero) ||
    (bitTest && (fileRd[bitSel] == instrQ[8])));
  assign pclWrite = fileWe && (effAddr == risc_core_pkg::ADDR_PCL);
  assign flush = isGoto || skip || pclWrite;
  assign pcInc = (pcQ == PC_LAST) ? '0 : pcQ + 1'b1;
  assign pcD = isGoto ? instrQ[8:0] :
    pclWrite ? {1'b0, result} : pcInc;
  assign validD = !flush;
  assign wD = (validQ && dec.toW) ? result : wQ;

  always_comb
  begin
    statusD = (fileWe && effAddr == risc_core_pkg::ADDR_STATUS) ? result : statusQ;
    // Flag updates override a direct write to the status byte
    if (validQ && dec.affCarry)
    begin
      statusD[risc_core_pkg::ST_CARRY] = aluFlags.carry;
    end
    if (validQ && dec.affNibble)
    begin
      statusD[risc_core_pkg::ST_NIBBLE] = aluFlags.nibble;
    end
    if (validQ && dec.affZero)
    begin
      statusD[risc_core_pkg::ST_ZERO] = aluFlags.zero;
    end
  end

  // ****************************************
  // Pipeline and program counter
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pcQ <= risc_core_pkg::PC_RESET;
      instrQ <= risc_core_pkg::INSTR_NOP;
      validQ <= 1'b0;
    end
    else
    begin
      pcQ <= pcD;
      instrQ <= progData;
      validQ <= validD;
    end
  end

  // ****************************************
  // Working and special registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wQ <= risc_core_pkg::DATA_RESET;
      statusQ <= risc_core_pkg::STATUS_RESET;
      fsrQ <= risc_core_pkg::DATA_RESET;
      outAQ <= risc_core_pkg::DATA_RESET;
      outBQ <= risc_core_pkg::DATA_RESET;
    end
    else
    begin
      wQ <= wD;
      statusQ <= statusD;
      if (fileWe && effAddr == risc_core_pkg::ADDR_FSR)
      begin
        fsrQ <= result;
      end
      if (fileWe && effAddr == risc_core_pkg::ADDR_OUTA)
      begin
        outAQ <= result;
      end
      if (fileWe && effAddr == risc_core_pkg::ADDR_OUTB)
      begin
        outBQ <= result;
      end
    end
  end

  // ****************************************
  // General-purpose RAM
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < GPR_BYTES; i++)
      begin
        gprQ[i] <= risc_core_pkg::DATA_RESET;
      end
    end
    else if (fileWe && isGpr)
    begin
      gprQ[gprIdx] <= result;
    end
  end

  assign progAddr = pcQ;
  assign outA = outAQ;
  assign outB = outBQ;
  assign wOut = wQ;
  assign statusOut = statusQ;

endmodule

`default_nettype wire

// ---- tb/risc_core_alu_datapath_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none

module risc_core_alu_datapath_asserts #(
  parameter int PROG_WORDS = 512,
  parameter int GPR_BYTES = 25
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Program bus
  input wire logic [8:0] progAddr,
  input wire logic [11:0] progData,
  // Pins and observation
  input wire logic [7:0] pinsIn,
  input wire logic [7:0] outA,
  input wire logic [7:0] outB,
  input wire logic [7:0] wOut,
  input wire logic [7:0] statusOut
);
  default clocking cb @(posedge clk);
  endclocking

  // ****************************************
  // Sequences
  // ****************************************
  // A literal word cannot branch, so the word after it always executes
  sequence s_lit;
    !sys_rst && progData[11:10] == 2'h3;
  endsequence

  sequence s_lit_then(logic [3:0] top);
    s_lit ##1 (!sys_rst && progData[11:8] == top) ##1 !sys_rst;
  endsequence

  sequence s_goto;
    s_lit ##1 (!sys_rst && progData[11:9] == 3'h4) ##1 !sys_rst;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_reset_pc_zero: assert property (sys_rst |=> progAddr == 9'h000)
    else $error("program address not cleared by reset");
  a_reset_outs_clear: assert property (sys_rst |=> wOut == 8'h00 && outA == 8'h00
    && outB == 8'h00 && statusOut == risc_core_pkg::STATUS_RESET)
    else $error("outputs not cleared by reset");
  a_fetch_next_word: assert property (disable iff (sys_rst)
    s_lit ##1 !sys_rst |=> progAddr == $past(progAddr) + 9'h001)
    else $error("fetch address did not advance by one");
  a_goto_target: assert property (disable iff (sys_rst)
    s_goto |=> progAddr == $past(progData[8:0], 2))
    else $error("jump did not load its target");
  a_branch_second_cycle: assert property (disable iff (sys_rst)
    s_goto |=> ##1 progAddr == $past(progData[8:0], 3) + 9'h001)
    else $error("discarded word after jump disturbed the fetch");
  a_lit_move_w: assert property (disable iff (sys_rst)
    s_lit_then(4'hC) |=> wOut == $past(progData[7:0], 2))
    else $error("literal move not in working register after one cycle");
  a_lit_move_flags: assert property (disable iff (sys_rst)
    s_lit_then(4'hC) |=> $stable(statusOut) && $stable(outA) && $stable(outB))
    else $error("literal move disturbed status or latches");
  a_lit_xor_zero: assert property (disable iff (sys_rst)
    s_lit_then(4'hF) |=> wOut == ($past(wOut) ^ $past(progData[7:0], 2))
    && statusOut[risc_core_pkg::ST_ZERO] == (wOut == 8'h00)
    && statusOut[1:0] == $past(statusOut[1:0]))
    else $error("literal xor result or zero flag wrong");
endmodule

bind risc_core_alu_datapath risc_core_alu_datapath_asserts #(
  .PROG_WORDS(PROG_WORDS),
  .GPR_BYTES(GPR_BYTES)
) u_risc_core_alu_datapath_asserts (
  .clk(clk),
  .sys_rst(sys_rst),
  .progAddr(progAddr),
  .progData(progData),
  .pinsIn(pinsIn),
  .outA(outA),
  .outB(outB),
  .wOut(wOut),
  .statusOut(statusOut)
);

`default_nettype wire

// ---- tb/prog_rom_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module prog_rom_model #(
  parameter int WORDS = 512
) (
  // Program bus
  input wire logic [8:0] progAddr,
  output logic [11:0] progData
);
  // Loaded by the bench while the core is held in reset
  logic [11:0] mem [WORDS];

  // Whole 12-bit word per address, all of it on chip
  assign progData = mem[progAddr];
endmodule

`default_nettype wire

// ---- tb/risc_core_alu_datapath_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module risc_core_alu_datapath_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] progAddr;
  logic [11:0] progData;
  logic [7:0] pinsIn = 8'hA5;
  logic [7:0] outA;
  logic [7:0] outB;
  logic [7:0] wOut;
  logic [7:0] statusOut;
  int miscompares = 0;
  int comparisons = 0;

  always #10 clk = ~clk;

  risc_core_alu_datapath u_risc_core_alu_datapath (
    .clk(clk),
    .sys_rst(sys_rst),
    .progAddr(progAddr),
    .progData(progData),
    .pinsIn(pinsIn),
    .outA(outA),
    .outB(outB),
    .wOut(wOut),
    .statusOut(statusOut)
  );

  prog_rom_model u_prog_rom_model (
    .progAddr(progAddr),
    .progData(progData)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Last word must jump to itself; reset is long enough to load the memory
  task automatic run_prog(input logic [11:0] prog [$]);
    int n;
    n = 0;
    @(negedge clk);
    sys_rst = 1'b1;
    for (int i = 0; i < 512; i++)
      u_prog_rom_model.mem[i] = risc_core_pkg::INSTR_NOP;
    foreach (prog[i])
      u_prog_rom_model.mem[i] = prog[i];
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    while (progAddr !== 9'(prog.size() - 1) && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check({7'h00, n < 200}, 8'h01);
    repeat (3) @(negedge clk);
  endtask

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Each literal mode applied to a loaded working register
  task automatic lit_ops();
    logic [7:0] lit [4] = '{8'h3C, 8'h0F, 8'h0F, 8'h5A};
    logic [7:0] exp [4] = '{8'h3C, 8'h5F, 8'h0A, 8'h00};
    for (int k = 0; k < 4; k++)
    begin
      run_prog('{12'hC5A, {2'h3, 2'(k), lit[k]}, 12'h802});
      check(wOut, exp[k]);
      check(statusOut, (exp[k] == 8'h00) ? 8'h04 : 8'h00);
    end
  endtask

  // File minus or plus working register, flags worked out independently
  task automatic arith(input logic sub, input logic [7:0] x, input logic [7:0] y);
    logic [8:0] r;
    logic c;
    logic n;
    r = sub ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    c = sub ? (x >= y) : r[8];
    n = sub ? (x[3:0] >= y[3:0]) : (({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F);
    run_prog('{{4'hC, x}, 12'h027, {4'hC, y}, sub ? 12'h087 : 12'h1C7, 12'h804});
    check(wOut, r[7:0]);
    check(statusOut, {5'h00, r[7:0] == 8'h00, n, c});
  endtask

  // Rotate, indirect read, pins, program counter read, latch writes
  task automatic file_ops();
    pinsIn = 8'h3C;
    run_prog('{12'hC81, 12'h028, 12'h368, 12'hC08, 12'h024, 12'h200,
               12'h025, 12'h201, 12'h026, 12'h202, 12'h80A});
    check(outA, 8'h02);
    check(outB, 8'h3C);
    check(wOut, 8'h0A);
    check(statusOut, 8'h01);
  endtask

  // Jump over a word, skip on zero using the last general byte
  task automatic branch_skip();
    run_prog('{12'hC11, 12'h803, 12'hC22, 12'h025, 12'hCFF, 12'h03F,
               12'h3FF, 12'h026, 12'h808});
    check(outA, 8'h11);
    check(outB, 8'h00);
    check(wOut, 8'hFF);
    check(statusOut, 8'h00);
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial
  begin
    lit_ops();
    arith(1'b0, 8'h0F, 8'h01);
    arith(1'b0, 8'hFF, 8'h01);
    arith(1'b1, 8'h05, 8'h06);
    arith(1'b1, 8'h10, 8'h10);
    arith(1'b1, 8'h10, 8'h01);
    file_ops();
    branch_skip();
    final_report();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule

`default_nettype wire
